// [shared/motion_status_pkg.sv]
// constants shared by the posture and knock status block
// assumes 12-bit two's complement filtered samples, 1024 lsb/g in 2g range
package motion_status_pkg;
  // data widths
  localparam int ACC_W = 12; // filtered sample width
  localparam int CALC_W = 16; // headroom for doubled magnitudes plus margin
  localparam int IDX_W = 8; // register index width
  localparam int ADDR_LSB = 2; // byte address is four times the index
  // register indices
  localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'h09; // interrupt status
  localparam logic [IDX_W-1:0] IDX_TAP_INFO = 8'h0B; // tap axis and sign
  localparam logic [IDX_W-1:0] IDX_ORIENT = 8'h0C; // orientation code
  localparam logic [IDX_W-1:0] IDX_RANGE = 8'h0F; // acceleration range
  localparam logic [IDX_W-1:0] IDX_INT_EN = 8'h16; // interrupt enables
  localparam logic [IDX_W-1:0] IDX_TAP_CFG = 8'h2B; // tap sample count
  localparam logic [IDX_W-1:0] IDX_ORIENT_CFG = 8'h2C; // scheme and margin
  localparam logic [IDX_W-1:0] IDX_ORIENT_FLIP = 8'h2D; // vertical flip
  // field positions
  localparam int INT_ORIENT_BIT = 6;
  localparam int TAP_X_BIT = 4;
  localparam int TAP_Y_BIT = 5;
  localparam int TAP_Z_BIT = 6;
  localparam int TAP_SIGN_BIT = 7;
  localparam int ORIENT_LSB = 4; // three-bit code at 6:4
  localparam int EN_ORIENT_BIT = 6;
  localparam int SAMP_LSB = 6; // two bits at 7:6
  localparam int MODE_LSB = 0; // two bits at 1:0
  localparam int HYST_LSB = 4; // three bits at 6:4
  localparam int HYST_W = 3;
  localparam int FLIP_BIT = 6;
  localparam int RANGE_LSB = 0; // two bits at 1:0
  // scheme codes
  localparam logic [1:0] MODE_HIGH = 2'h1;
  localparam logic [1:0] MODE_LOW = 2'h2;
  // tap axis codes
  localparam logic [1:0] AXIS_X = 2'h0;
  localparam logic [1:0] AXIS_Y = 2'h1;
  localparam logic [1:0] AXIS_Z = 2'h2;
  // x-y orientation codes
  localparam logic [1:0] XY_UP = 2'h0;
  localparam logic [1:0] XY_DOWN = 2'h1;
  localparam logic [1:0] XY_LEFT = 2'h2;
  localparam logic [1:0] XY_RIGHT = 2'h3;
  // scaling
  localparam int LSB_PER_G_2G = 1024;
  localparam int MARGIN_UG = 62500; // margin step in micro-g
  localparam int ZHYST_MG = 200; // z hysteresis in milli-g
  localparam int MARGIN_CNT_2G = MARGIN_UG * LSB_PER_G_2G / 1000000;
  localparam int ZHYST_CNT_2G = ZHYST_MG * LSB_PER_G_2G / 1000;
  localparam int TAP_SAMP_BASE = 2; // 2 samples for code 00b
  localparam int SAMP_CNT_W = 5;
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [7:0] REG_RST = 8'h00;
endpackage

// [logic/posture_knock_status.sv]
// posture and knock status logic with an ahb-lite register slave
// assumes samples, tap events and clears come from logic on mclk
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module posture_knock_status
  import motion_status_pkg::*;
(
  input wire logic mclk, // 40 mhz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic sample_valid, // one-cycle pulse, new filtered sample
  input wire logic signed [ACC_W-1:0] acc_x, // filtered x
  input wire logic signed [ACC_W-1:0] acc_y, // filtered y
  input wire logic signed [ACC_W-1:0] acc_z, // filtered z
  input wire logic sleep_phase, // low-power sleep phase
  input wire logic low_power, // low-power mode selected
  input wire logic wake, // one-cycle pulse at wake-up
  input wire logic tap_event, // one-cycle pulse, tap detected
  input wire logic [1:0] tap_axis, // axis of first tap
  input wire logic tap_negative, // first tap slope negative
  input wire logic tap_int_clear, // one-cycle pulse, tap status cleared
  output logic tap_eval_en, // tap detector may evaluate this sample
  output logic [2:0] orient_code, // present orientation
  output logic orient_irq // orientation interrupt
);

  // ---------------- bus slave ----------------
  logic wr_pend_reg, wr_pend_next; // write data phase pending
  logic [IDX_W-1:0] wr_idx_reg, wr_idx_next; // index of pending write
  logic [31:0] hrdata_reg, hrdata_next; // registered read data
  logic hreadyout_reg; // zero-wait ready
  logic hresp_reg; // response, fixed okay but still leaves a flop
  logic addr_ok; // valid word access in address phase
  logic [IDX_W-1:0] a_idx; // index decoded from address
  logic wr_now; // write data applied this cycle
  logic [7:0] wr_byte; // low byte of write data
  // software registers
  logic en_reg, en_next; // orientation interrupt enable
  logic [1:0] samp_reg, samp_next; // tap sample count code
  logic [1:0] mode_reg, mode_next; // threshold scheme
  logic [HYST_W-1:0] hyst_reg, hyst_next; // margin steps
  logic flip_reg, flip_next; // vertical flip consider
  logic [1:0] range_reg, range_next; // acceleration range
  // status state that the read mux looks at, declared ahead of its first use
  logic tfx_reg, tfx_next; // x caused the tap
  logic tfy_reg, tfy_next; // y caused the tap
  logic tfz_reg, tfz_next; // z caused the tap
  logic tsign_reg, tsign_next; // first slope negative
  logic oint_reg, oint_next; // orientation interrupt status
  logic [2:0] code_next; // next code as read back

  assign a_idx = haddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
  assign wr_now = wr_pend_reg;
  assign wr_byte = hwdata[7:0];

  // address phase capture and register writes
  always_comb begin
    wr_pend_next = addr_ok & hwrite;
    wr_idx_next = addr_ok ? a_idx : wr_idx_reg;
    en_next = en_reg;
    samp_next = samp_reg;
    mode_next = mode_reg;
    hyst_next = hyst_reg;
    flip_next = flip_reg;
    range_next = range_reg;
    if (wr_now) begin
      unique case (wr_idx_reg)
        IDX_INT_EN: en_next = wr_byte[EN_ORIENT_BIT];
        IDX_TAP_CFG: samp_next = wr_byte[SAMP_LSB+:2];
        IDX_ORIENT_CFG: begin
          mode_next = wr_byte[MODE_LSB+:2];
          hyst_next = wr_byte[HYST_LSB+:HYST_W];
        end
        IDX_ORIENT_FLIP: flip_next = wr_byte[FLIP_BIT];
        IDX_RANGE: range_next = wr_byte[RANGE_LSB+:2];
        default: ; // read-only or unmapped: write ignored
      endcase
    end
  end

  // read mux, from next values so a read right after a write sees it
  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (addr_ok & ~hwrite) begin
      unique case (a_idx)
        IDX_INT_STATUS: hrdata_next[INT_ORIENT_BIT] = oint_next;
        IDX_TAP_INFO: begin
          hrdata_next[TAP_X_BIT] = tfx_next;
          hrdata_next[TAP_Y_BIT] = tfy_next;
          hrdata_next[TAP_Z_BIT] = tfz_next;
          hrdata_next[TAP_SIGN_BIT] = tsign_next;
        end
        IDX_ORIENT: hrdata_next[ORIENT_LSB+:3] = code_next;
        IDX_INT_EN: hrdata_next[EN_ORIENT_BIT] = en_next;
        IDX_TAP_CFG: hrdata_next[SAMP_LSB+:2] = samp_next;
        IDX_ORIENT_CFG: begin
          hrdata_next[MODE_LSB+:2] = mode_next;
          hrdata_next[HYST_LSB+:HYST_W] = hyst_next;
        end
        IDX_ORIENT_FLIP: hrdata_next[FLIP_BIT] = flip_next;
        IDX_RANGE: hrdata_next[RANGE_LSB+:2] = range_next;
        default: hrdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // bus and configuration flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= REG_RST;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
      en_reg <= 1'b0;
      samp_reg <= 2'h0;
      mode_reg <= 2'h0;
      hyst_reg <= 3'h0;
      flip_reg <= 1'b0;
      range_reg <= 2'h0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
      en_reg <= en_next;
      samp_reg <= samp_next;
      mode_reg <= mode_next;
      hyst_reg <= hyst_next;
      flip_reg <= flip_next;
      range_reg <= range_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // ---------------- tap axis and sign ----------------

  // a new tap beats a clear in the same cycle so the event is not lost
  always_comb begin
    tfx_next = tfx_reg;
    tfy_next = tfy_reg;
    tfz_next = tfz_reg;
    tsign_next = tsign_reg;
    if (tap_event) begin
      tsign_next = tap_negative;
      tfx_next = (tap_axis == AXIS_X);
      tfy_next = (tap_axis == AXIS_Y);
      tfz_next = (tap_axis == AXIS_Z);
    end else if (tap_int_clear) begin
      tfx_next = 1'b0;
      tfy_next = 1'b0;
      tfz_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tfx_reg <= 1'b0;
      tfy_reg <= 1'b0;
      tfz_reg <= 1'b0;
      tsign_reg <= 1'b0;
    end else begin
      tfx_reg <= tfx_next;
      tfy_reg <= tfy_next;
      tfz_reg <= tfz_next;
      tsign_reg <= tsign_next;
    end
  end

  // ---------------- low-power tap window ----------------
  logic [SAMP_CNT_W-1:0] scnt_reg, scnt_next; // samples seen since wake
  logic [SAMP_CNT_W-1:0] samp_lim; // samples allowed per wake
  logic tev_reg, tev_next; // evaluation enable flop

  assign samp_lim = SAMP_CNT_W'(TAP_SAMP_BASE) << samp_reg;

  // count samples after each wake; outside low power every sample counts
  always_comb begin
    scnt_next = scnt_reg;
    if (wake) begin
      scnt_next = '0;
    end else if (sample_valid & (scnt_reg < samp_lim)) begin
      scnt_next = scnt_reg + 1'b1;
    end
    tev_next = ~low_power | (scnt_next < samp_lim);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scnt_reg <= '0;
      tev_reg <= 1'b1;
    end else begin
      scnt_reg <= scnt_next;
      tev_reg <= tev_next;
    end
  end

  assign tap_eval_en = tev_reg;

  // ---------------- orientation ----------------
  logic [1:0] xy_reg, xy_next; // x-y part of code
  logic zb_reg, zb_next; // z sign part of code
  logic zref_reg, zref_next; // z direction last accepted for interrupts
  logic signed [CALC_W-1:0] sx, sy, sz; // widened samples
  logic signed [CALC_W-1:0] ax, ay, az; // magnitudes
  logic signed [CALC_W-1:0] kx; // scaled |x| per scheme
  logic signed [CALC_W-1:0] margin; // margin in sample lsb
  logic signed [CALC_W-1:0] zthr; // z hysteresis in sample lsb
  logic [1:0] xy_calc; // x-y decision of this sample
  logic z_event; // accepted z direction change
  logic change; // code change that raises the interrupt
  logic eval; // this cycle evaluates a sample

  assign sx = CALC_W'(acc_x);
  assign sy = CALC_W'(acc_y);
  assign sz = CALC_W'(acc_z);
  assign ax = sx[CALC_W-1] ? -sx : sx;
  assign ay = sy[CALC_W-1] ? -sy : sy;
  assign az = sz[CALC_W-1] ? -sz : sz;
  // margin step fixed in g, so fewer lsb in wider ranges
  assign margin = (CALC_W'(hyst_reg) * CALC_W'(MARGIN_CNT_2G)) >>> range_reg;
  assign zthr = CALC_W'(ZHYST_CNT_2G) >>> range_reg;
  assign eval = sample_valid & ~sleep_phase;

  // classify one sample; inside the margin band the old x-y code stays
  always_comb begin
    unique case (mode_reg)
      MODE_HIGH: kx = ax <<< 1;
      MODE_LOW: kx = ax >>> 1;
      default: kx = ax;
    endcase
    xy_calc = xy_reg;
    if (ay < kx - margin) begin
      if (sx - margin >= 0) begin
        xy_calc = XY_UP;
      end else if (sx + margin < 0) begin
        xy_calc = XY_DOWN;
      end
    end else if (ay >= kx + margin) begin
      xy_calc = sy[CALC_W-1] ? XY_LEFT : XY_RIGHT;
    end
    z_event = (sz[CALC_W-1] != zref_reg) & (az > zthr);
    change = (xy_calc != xy_reg) | (flip_reg & z_event);
    xy_next = xy_reg;
    zb_next = zb_reg;
    zref_next = zref_reg;
    oint_next = oint_reg & en_reg;
    if (eval) begin
      xy_next = xy_calc;
      zb_next = sz[CALC_W-1];
      zref_next = z_event ? sz[CALC_W-1] : zref_reg;
      oint_next = en_reg & change;
    end
    code_next = {zb_next, xy_next};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xy_reg <= XY_UP;
      zb_reg <= 1'b0;
      zref_reg <= 1'b0;
      oint_reg <= 1'b0;
    end else begin
      xy_reg <= xy_next;
      zb_reg <= zb_next;
      zref_reg <= zref_next;
      oint_reg <= oint_next;
    end
  end

  assign orient_code = {zb_reg, xy_reg};
  assign orient_irq = oint_reg;

  // ---------------- assertions ----------------
  tap_sign_keep_a: assert property (@(posedge mclk) disable iff (rst)
    (tap_int_clear & ~tap_event) |=> $stable(tsign_reg))
    else $error("tap sign changed on clear");
  tap_sign_set_a: assert property (@(posedge mclk) disable iff (rst)
    tap_event |=> (tsign_reg == $past(tap_negative)))
    else $error("tap sign not recorded");
  tap_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    (tap_event & (tap_axis != 2'h3)) |=> $onehot({tfx_reg, tfy_reg, tfz_reg}))
    else $error("tap axis flags not one-hot");
  tap_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (tap_int_clear & ~tap_event) |=> ({tfx_reg, tfy_reg, tfz_reg} == 3'h0))
    else $error("tap axis flags not cleared");
  samp_window_a: assert property (@(posedge mclk) disable iff (rst)
    (low_power & (scnt_reg >= samp_lim) & ~wake) |=> ~tap_eval_en)
    else $error("tap window exceeded");
  z_msb_a: assert property (@(posedge mclk) disable iff (rst)
    eval |=> (orient_code[2] == $past(acc_z[ACC_W-1])))
    else $error("code msb not z sign");
  sleep_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (sleep_phase | ~sample_valid) |=> $stable(orient_code))
    else $error("code moved without a sample");
  int_raise_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & en_reg & (xy_calc != xy_reg)) |=> orient_irq)
    else $error("no interrupt on code change");
  int_stable_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & ~change) |=> ~orient_irq)
    else $error("interrupt kept after stable sample");
  int_enable_a: assert property (@(posedge mclk) disable iff (rst)
    ~en_reg |=> ~orient_irq)
    else $error("interrupt while disabled");
  flip_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & ~flip_reg & (xy_calc == xy_reg)) |=> ~orient_irq)
    else $error("z change raised interrupt while ignored");
  z_noise_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & (xy_calc == xy_reg) & (az <= zthr)) |=> ~orient_irq)
    else $error("small z swing raised interrupt");
  tap_window_open_a: assert property (@(posedge mclk) disable iff (rst)
    (low_power & wake) |=> tap_eval_en)
    else $error("tap window closed after wake");

  // threshold decisions, checked on the code that the next edge shows
  portrait_up_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & (ay < kx - margin) & (sx - margin >= 0)) |=> (orient_code[1:0] == XY_UP))
    else $error("portrait upright not reported");
  portrait_down_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & (ay < kx - margin) & (sx + margin < 0)) |=> (orient_code[1:0] == XY_DOWN))
    else $error("portrait upside down not reported");
  landscape_sel_a: assert property (@(posedge mclk) disable iff (rst)
    (eval & (ay >= kx + margin)) |=> orient_code[1])
    else $error("landscape not reported");

  // a read must see the same state that the output pins show
  status_mirror_a: assert property (@(posedge mclk) disable iff (rst)
    (addr_ok & ~hwrite & (a_idx == IDX_INT_STATUS)) |=> (hrdata[INT_ORIENT_BIT] == orient_irq))
    else $error("status bit differs from interrupt");
  code_readback_a: assert property (@(posedge mclk) disable iff (rst)
    (addr_ok & ~hwrite & (a_idx == IDX_ORIENT)) |=> (hrdata[ORIENT_LSB+:3] == orient_code))
    else $error("read code differs from output");

endmodule
`default_nettype wire

// [verification/ahb_host_model.sv]
// host side model: an ahb-lite master doing single word transfers
// assumes the slave on mclk, its hreadyout looped back as hready
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model
  import motion_status_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic cmd_valid, // bench command, held until done
  input wire logic cmd_write, // write when high
  input wire logic [7:0] cmd_idx, // register index
  input wire logic [7:0] cmd_wdata, // low byte to write
  output logic cmd_done, // one-cycle completion
  output logic [7:0] cmd_rdata, // low byte read
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // direction
  output logic [2:0] hsize, // always a word
  output logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata // read data
);
  logic [1:0] st_reg; // 0 idle, 1 address phase, 2 data phase
  // done blocks a relaunch while the bench drops its command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= 2'h0;
      cmd_done <= 1'b0;
      cmd_rdata <= 8'h00;
      haddr <= 32'h0000_0000;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= HSIZE_WORD;
      hwdata <= 32'h0000_0000;
    end else begin
      cmd_done <= 1'b0;
      if (st_reg == 2'h0 && cmd_valid && !cmd_done) begin
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h00_0000, cmd_idx, 2'h0};
        hwrite <= cmd_write;
        st_reg <= 2'h1;
      end else if (st_reg == 2'h1 && hready) begin
        htrans <= 2'h0; // idle once the address is taken
        hwdata <= {24'h00_0000, cmd_wdata};
        st_reg <= 2'h2;
      end else if (st_reg == 2'h2 && hready) begin
        cmd_rdata <= hrdata[7:0];
        cmd_done <= 1'b1;
        hwdata <= ~hwdata; // released data must not look valid
        st_reg <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/posture_knock_status_tb.sv]
// bench for the posture and knock status block
// assumes the host model as bus master; reads are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module posture_knock_status_tb;
  import motion_status_pkg::*;
  logic mclk = 1'b0; // 40 mhz clock
  logic rst = 1'b0; // raised at time zero
  logic hsel = 1'b1; // single slave, always selected
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hwrite, hready, hresp, cmd_done, tap_eval_en, orient_irq;
  logic cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [7:0] cmd_idx = 8'h00, cmd_wdata = 8'h00, cmd_rdata;
  logic sample_valid = 1'b0, sleep_phase = 1'b0, low_power = 1'b0, wake = 1'b0;
  logic signed [ACC_W-1:0] acc_x = '0, acc_y = '0, acc_z = '0;
  logic tap_event = 1'b0, tap_negative = 1'b0, tap_int_clear = 1'b0;
  logic [1:0] tap_axis = 2'h0;
  logic [2:0] orient_code;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  logic [1:0] xy_prev, xy; // bench view of the x-y code
  int error_cnt = 0;
  int n_checks = 0;
  int x, y, z, md, hy;

  always #12.5 mclk = ~mclk;

  posture_knock_status i_posture_knock_status (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .sample_valid(sample_valid), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
    .sleep_phase(sleep_phase), .low_power(low_power), .wake(wake), .tap_event(tap_event),
    .tap_axis(tap_axis), .tap_negative(tap_negative), .tap_int_clear(tap_int_clear),
    .tap_eval_en(tap_eval_en), .orient_code(orient_code), .orient_irq(orient_irq));

  ahb_host_model i_ahb_host_model (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done),
    .cmd_rdata(cmd_rdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  // one bus command through the host model, bounded wait
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_idx <= idx;
    cmd_wdata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (cmd_done !== 1'b1 && n < 50);
    if (cmd_done !== 1'b1) begin
      fail("bus transfer hung");
      finish_test();
    end
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask

  // a read notes its expected byte first; the monitor compares it
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask

  // one filtered sample, pulse of one cycle
  task automatic samp(input int sx, input int sy, input int sz);
    @(posedge mclk);
    sample_valid <= 1'b1;
    acc_x <= sx[ACC_W-1:0];
    acc_y <= sy[ACC_W-1:0];
    acc_z <= sz[ACC_W-1:0];
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask

  // sample, then read code and status
  task automatic samp_chk(input int sx, input int sy, input int sz, input logic [2:0] c,
    input logic q);
    samp(sx, sy, sz);
    #1;
    n_checks++;
    if (orient_code !== c) fail("orientation code output");
    n_checks++;
    if (orient_irq !== q) fail("orientation interrupt output");
    rd(IDX_ORIENT, {1'b0, c, 4'h0});
    rd(IDX_INT_STATUS, {1'b0, q, 6'h00});
  endtask

  // x-y decision from the threshold tables; inside the band the code is kept
  function automatic logic [1:0] xy_calc(input int sx, input int sy, input int m,
    input int mode, input logic [1:0] old);
    int ax, ay, t;
    ax = (sx < 0) ? -sx : sx;
    ay = (sy < 0) ? -sy : sy;
    t = (mode == 1) ? 2 * ax : (mode == 2) ? ax / 2 : ax;
    if (ay < t - m) return (sx - m >= 0) ? XY_UP : (sx + m < 0) ? XY_DOWN : old;
    if (ay >= t + m) return (sy < 0) ? XY_LEFT : XY_RIGHT;
    return old;
  endfunction

  // result watcher: each completed read takes the oldest note
  always @(posedge mclk) begin
    if (cmd_done === 1'b1 && cmd_write === 1'b0) begin
      n_checks++;
      if (hresp !== HRESP_OKAY) fail("response not okay");
      if (exp_q.size() == 0) begin
        fail("read without expectation");
      end else begin
        if (cmd_rdata !== exp_q[0]) fail($sformatf("idx %h got %h", cmd_idx, cmd_rdata));
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    rst = 1'b1;
    void'($urandom(15264));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // reset values, a read-only and an unmapped place
    rd(IDX_ORIENT, 8'h00);
    rd(IDX_INT_STATUS, 8'h00);
    rd(IDX_TAP_INFO, 8'h00);
    bus(1'b1, IDX_ORIENT, 8'h70);
    rd(IDX_ORIENT, 8'h00);
    rd(8'h3F, 8'h00);
    bus(1'b1, IDX_INT_EN, 8'h40);
    rd(IDX_INT_EN, 8'h40);
    // every tap axis, sign flipping between events, then a clear
    for (int a = 0; a < 3; a++) begin
      @(posedge mclk);
      tap_event <= 1'b1;
      tap_axis <= a[1:0];
      tap_negative <= a[0];
      @(posedge mclk);
      tap_event <= 1'b0;
      rd(IDX_TAP_INFO, {a[0], 3'(1 << a), 4'h0});
      @(posedge mclk);
      tap_int_clear <= 1'b1;
      @(posedge mclk);
      tap_int_clear <= 1'b0;
      rd(IDX_TAP_INFO, {a[0], 7'h00});
    end
    // low-power sample window for each count code
    @(posedge mclk);
    low_power <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, IDX_TAP_CFG, 8'(s << 6));
      @(posedge mclk);
      wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      for (int k = 0; k <= (2 << s); k++) begin
        repeat (3) @(posedge mclk);
        #1;
        n_checks++;
        if (tap_eval_en !== (k < (2 << s))) fail("tap sample window");
        samp(1000, 0, 500);
      end
    end
    @(posedge mclk);
    low_power <= 1'b0;
    // random samples across all schemes and margins
    xy_prev = XY_UP;
    for (int i = 0; i < 40; i++) begin
      md = i % 4;
      hy = $urandom_range(7, 0);
      bus(1'b1, IDX_ORIENT_CFG, {1'b0, hy[2:0], 2'h0, md[1:0]});
      x = ($urandom_range(4000, 0) - 2000) & ~1; // even, so half of |x| is exact
      y = $urandom_range(4000, 0) - 2000;
      z = $urandom_range(1000, 0) - 500;
      xy = xy_calc(x, y, hy * MARGIN_CNT_2G, md, xy_prev);
      samp_chk(x, y, z, {z < 0, xy}, xy != xy_prev);
      xy_prev = xy;
    end
    // z handling, hysteresis, enable and sleep
    bus(1'b1, IDX_ORIENT_CFG, 8'h00);
    samp(1000, 0, 500);
    samp_chk(1000, 0, 500, 3'h0, 1'b0);
    samp_chk(1000, 0, -500, 3'h4, 1'b0);
    bus(1'b1, IDX_ORIENT_FLIP, 8'h40);
    samp(1000, 0, 500);
    samp_chk(1000, 0, 500, 3'h0, 1'b0);
    samp_chk(1000, 0, -100, 3'h4, 1'b0);
    samp_chk(1000, 0, -300, 3'h4, 1'b1);
    bus(1'b1, IDX_INT_EN, 8'h00);
    samp_chk(-1000, 0, -300, 3'h5, 1'b0);
    @(posedge mclk);
    sleep_phase <= 1'b1;
    samp(1000, 0, 500);
    rd(IDX_ORIENT, 8'h50);
    @(posedge mclk);
    sleep_phase <= 1'b0;
    repeat (5) @(posedge mclk);
    if (exp_q.size() != 0) fail("reads left unanswered");
    finish_test();
  end
endmodule
`default_nettype wire
